// >>> design/msc_regs.svh
// Operation
// - Interrupt low while enabled flag set
// - Mask bit gates its flag onto interrupt
// - Pulse 2 direction change sets bit 5
// - Pulse 1 direction change sets bit 4
// - Wiring bits 7:4 enable current integrators
// - Wiring field selects phase B formula
// - Slot skip bit disables slot conversion
// - Mux field routes differential input pair
// - Gain field sets power-of-two gain
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

`define MSC_ADDR_W            8
`define MSC_DATA_W            16

`define MSC_OFS_EVENT_FLAGS   8'h04
`define MSC_OFS_IRQ_ENABLE    8'h06
`define MSC_OFS_RESET_CAUSE   8'h08
`define MSC_OFS_WIRING        8'h0a
`define MSC_OFS_SLOT0         8'h10

`define MSC_RST_EVENT_FLAGS   16'h0001
`define MSC_RST_IRQ_ENABLE    16'h0001
`define MSC_RST_RESET_CAUSE   16'h0000
`define MSC_RST_WIRING        16'h0000
`define MSC_RST_SLOT0         16'h0301

// Writable bits; reserved bits read as zero, except slot0 bit 0, which reads one from reset until the first write
`define MSC_MASK_EVENTS       16'h0f3f
`define MSC_MASK_RESET_CAUSE  16'h0084
`define MSC_MASK_WIRING       16'h00f7
`define MSC_MASK_SLOT0        16'h0ffe

`define MSC_BIT_NO_CROSSING   11
`define MSC_BIT_SAG           10
`define MSC_BIT_HIGH_VOLT     9
`define MSC_BIT_EXCESS_CURR   8
`define MSC_BIT_PULSE2_DIR    5
`define MSC_BIT_PULSE1_DIR    4
`define MSC_BIT_ENERGY_WRAP   3
`define MSC_BIT_TEMP_READY    2
`define MSC_BIT_SUPPLY_FAIL   1
`define MSC_BIT_UNINIT        0

`define MSC_BIT_POWERON       7
`define MSC_BIT_PULSE2_REV    5
`define MSC_BIT_PULSE1_REV    4
`define MSC_BIT_WATCHDOG      2

`define MSC_BIT_INTEG_HI      7
`define MSC_BIT_INTEG_LO      4
`define MSC_BIT_NEUTRAL_ON    2
`define MSC_BIT_WIRING_HI     1
`define MSC_BIT_WIRING_LO     0

`define MSC_BIT_MUX_HI        11
`define MSC_BIT_MUX_LO        8
`define MSC_BIT_SLOT_SKIP     7
`define MSC_BIT_GAIN_HI       6
`define MSC_BIT_GAIN_LO       4

`define MSC_MUX_LAST_VALID    4'h6
`define MSC_GAIN_LAST_VALID   3'h5

`endif

// >>> design/msc_pkg.sv
package msc_pkg;

    typedef logic [15:0] msc_word_t;

    typedef enum logic [1:0] {
        MSC_PB_OWN,
        MSC_PB_NEG_SUM,
        MSC_PB_NEG_VA
    } msc_phase_b_e;

    typedef struct packed {
        msc_word_t flags;
    } msc_bank_s;

    typedef struct packed {
        msc_word_t    irq_enable;
        msc_word_t    reset_cause;
        msc_word_t    wiring;
        msc_word_t    slot0;
        msc_word_t    rdata;
        logic         pulse1_rev_prev;
        logic         pulse2_rev_prev;
        logic         irq_n;
        logic [3:0]   integrator_on;
        logic         neutral_on;
        msc_phase_b_e phase_b_mode;
        logic         slot_skip;
        logic [3:0]   mux_select;
        logic         mux_valid;
        logic [2:0]   gain_select;
        logic [5:0]   gain_factor;
        logic         gain_valid;
    } msc_state_s;

endpackage

// >>> design/msc_flag_bank.sv
`timescale 1ns/1ps
`include "msc_regs.svh"

// Sticky flags: hardware set wins over a host write in the same cycle
module msc_flag_bank
    import msc_pkg::*;
#(
    parameter int        W        = 16,
    parameter logic [15:0] RST_VAL = `MSC_RST_EVENT_FLAGS,
    parameter logic [15:0] WR_MASK = `MSC_MASK_EVENTS
)
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           wr,
    input  wire logic [W-1:0]   wdata,
    input  wire logic [W-1:0]   set,
    output msc_pkg::msc_word_t  flags
);
    import msc_pkg::*;

    msc_bank_s    st_r;
    msc_bank_s    st_nxt;
    logic [W-1:0] bit_nxt;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            assign bit_nxt[i] = WR_MASK[i] &
                ((wr ? wdata[i] : st_r.flags[i]) | set[i]);
        end
    endgenerate

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.flags = msc_word_t'(bit_nxt);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '{flags: RST_VAL};
        else
            st_r <= st_nxt;
    end

    assign flags = st_r.flags;

endmodule

// >>> design/msc_top.sv
`timescale 1ns/1ps
`include "msc_regs.svh"

// Host-visible status, interrupt and configuration bank of the metering
// front-end. The serial engine in front of it presents decoded byte
// addresses with one-cycle read and write strobes.
module msc_top
    import msc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // Register port from the serial engine
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_rd,
    output msc_pkg::msc_word_t          reg_rdata,

    // Metering events: one-cycle pulses, or levels that set every cycle; the two pulse directions are levels whose changes set a flag
    input  wire logic                   no_crossing_evt,
    input  wire logic                   sag_evt,
    input  wire logic                   high_line_volt_evt,
    input  wire logic                   excess_current_evt,
    input  wire logic                   energy_wrap_evt,
    input  wire logic                   temp_ready_evt,
    input  wire logic                   supply_fail_evt,
    input  wire logic                   poweron_evt,
    input  wire logic                   watchdog_evt,
    input  wire logic                   pulse1_reversed,
    input  wire logic                   pulse2_reversed,

    // Interrupt pin and decoded configuration, all registered
    output logic                        host_interrupt_n,
    output logic                        neutral_integrator_on,
    output logic                        phase_c_integrator_on,
    output logic                        phase_b_integrator_on,
    output logic                        phase_a_integrator_on,
    output logic                        neutral_current_on,
    output msc_pkg::msc_phase_b_e       phase_b_mode,
    output logic                        slot_skip,
    output logic [3:0]                  mux_select,
    output logic                        mux_valid,
    output logic [2:0]                  gain_select,
    output logic [5:0]                  gain_factor,
    output logic                        gain_valid
);
    import msc_pkg::*;

    logic       rst_meta_r;
    logic       rst_n;
    msc_state_s st_r;
    msc_state_s st_nxt;
    msc_word_t  event_flags;
    msc_word_t  event_set;
    logic       wr_events;
    logic       dir1_flip;
    logic       dir2_flip;

    // Release reset synchronously, assert it at once
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // Any difference from last cycle's direction is a flip; the history
    // clears with reset, so an input already reversed at release flags once
    assign dir1_flip = pulse1_reversed ^ st_r.pulse1_rev_prev;
    assign dir2_flip = pulse2_reversed ^ st_r.pulse2_rev_prev;
    assign wr_events = reg_wr && (reg_addr == `MSC_OFS_EVENT_FLAGS);

    always_comb
    begin
        // Bit 0 has no hardware source; only reset and the host set it
        event_set                               = '0;
        event_set[`MSC_BIT_NO_CROSSING]         = no_crossing_evt;
        event_set[`MSC_BIT_SAG]                 = sag_evt;
        event_set[`MSC_BIT_HIGH_VOLT]           = high_line_volt_evt;
        event_set[`MSC_BIT_EXCESS_CURR]         = excess_current_evt;
        event_set[`MSC_BIT_PULSE2_DIR]          = dir2_flip;
        event_set[`MSC_BIT_PULSE1_DIR]          = dir1_flip;
        event_set[`MSC_BIT_ENERGY_WRAP]         = energy_wrap_evt;
        event_set[`MSC_BIT_TEMP_READY]          = temp_ready_evt;
        event_set[`MSC_BIT_SUPPLY_FAIL]         = supply_fail_evt;
    end

    msc_flag_bank #(
        .W       (16),
        .RST_VAL (`MSC_RST_EVENT_FLAGS),
        .WR_MASK (`MSC_MASK_EVENTS)
    ) u_events (
        .clk   (clk),
        .rst_n (rst_n),
        .wr    (wr_events),
        .wdata (reg_wdata),
        .set   (event_set),
        .flags (event_flags)
    );

    always_comb
    begin
        st_nxt = st_r;

        st_nxt.pulse1_rev_prev = pulse1_reversed;
        st_nxt.pulse2_rev_prev = pulse2_reversed;

        // Reserved bits are dropped on write, so a careless host cannot
        // wake undefined behaviour
        if (reg_wr)
        begin
            case (reg_addr)
                `MSC_OFS_IRQ_ENABLE:
                    st_nxt.irq_enable = reg_wdata & `MSC_MASK_EVENTS;
                `MSC_OFS_RESET_CAUSE:
                    st_nxt.reset_cause = reg_wdata & `MSC_MASK_RESET_CAUSE;
                `MSC_OFS_WIRING:
                    st_nxt.wiring = reg_wdata & `MSC_MASK_WIRING;
                `MSC_OFS_SLOT0:
                    st_nxt.slot0 = reg_wdata & `MSC_MASK_SLOT0;
                default:
                    st_nxt.slot0 = st_r.slot0;
            endcase
        end

        // Reset causes are sticky; a new cause beats a host clear
        if (poweron_evt)
            st_nxt.reset_cause[`MSC_BIT_POWERON] = 1'b1;
        if (watchdog_evt)
            st_nxt.reset_cause[`MSC_BIT_WATCHDOG] = 1'b1;
        // Direction bits mirror the live pulse direction, not writable
        st_nxt.reset_cause[`MSC_BIT_PULSE2_REV] = pulse2_reversed;
        st_nxt.reset_cause[`MSC_BIT_PULSE1_REV] = pulse1_reversed;

        // Read data is captured once and held until the next read strobe
        if (reg_rd)
        begin
            case (reg_addr)
                `MSC_OFS_EVENT_FLAGS: st_nxt.rdata = event_flags;
                `MSC_OFS_IRQ_ENABLE:  st_nxt.rdata = st_r.irq_enable;
                `MSC_OFS_RESET_CAUSE: st_nxt.rdata = st_r.reset_cause;
                `MSC_OFS_WIRING:      st_nxt.rdata = st_r.wiring;
                `MSC_OFS_SLOT0:       st_nxt.rdata = st_r.slot0;
                default:              st_nxt.rdata = 16'h0000;
            endcase
        end

        // Level output: falls with any enabled flag, rises when none remain.
        // Registered so the pin cannot glitch while flags and mask change;
        // the price is one cycle of latency
        st_nxt.irq_n = ~|(event_flags & st_r.irq_enable);

        st_nxt.integrator_on =
            st_r.wiring[`MSC_BIT_INTEG_HI:`MSC_BIT_INTEG_LO];
        st_nxt.neutral_on = st_r.wiring[`MSC_BIT_NEUTRAL_ON];

        // Both 1x codes share the negated phase A formula
        case (st_r.wiring[`MSC_BIT_WIRING_HI:`MSC_BIT_WIRING_LO])
            2'b00:   st_nxt.phase_b_mode = MSC_PB_OWN;
            2'b01:   st_nxt.phase_b_mode = MSC_PB_NEG_SUM;
            default: st_nxt.phase_b_mode = MSC_PB_NEG_VA;
        endcase

        st_nxt.slot_skip  = st_r.slot0[`MSC_BIT_SLOT_SKIP];
        // Reserved mux codes pass through but are flagged invalid
        st_nxt.mux_select = st_r.slot0[`MSC_BIT_MUX_HI:`MSC_BIT_MUX_LO];
        st_nxt.mux_valid  =
            st_r.slot0[`MSC_BIT_MUX_HI:`MSC_BIT_MUX_LO] <= `MSC_MUX_LAST_VALID;

        st_nxt.gain_select = st_r.slot0[`MSC_BIT_GAIN_HI:`MSC_BIT_GAIN_LO];
        st_nxt.gain_valid  =
            st_r.slot0[`MSC_BIT_GAIN_HI:`MSC_BIT_GAIN_LO] <= `MSC_GAIN_LAST_VALID;
        // Reserved gain codes fall back to unity rather than wrap
        if (st_nxt.gain_valid)
            st_nxt.gain_factor = 6'h01 << st_nxt.gain_select;
        else
            st_nxt.gain_factor = 6'h01;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Decoded outputs follow the registers one cycle after release
            st_r                 <= '0;
            st_r.irq_enable      <= `MSC_RST_IRQ_ENABLE;
            st_r.reset_cause     <= `MSC_RST_RESET_CAUSE;
            st_r.wiring          <= `MSC_RST_WIRING;
            st_r.slot0           <= `MSC_RST_SLOT0;
            st_r.irq_n           <= 1'b1;
            st_r.phase_b_mode    <= MSC_PB_OWN;
            st_r.gain_factor     <= 6'h01;
            st_r.gain_valid      <= 1'b1;
            st_r.mux_valid       <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // Every output comes straight from a flop of the state struct
    assign reg_rdata             = st_r.rdata;
    assign host_interrupt_n      = st_r.irq_n;
    assign neutral_integrator_on = st_r.integrator_on[3];
    assign phase_c_integrator_on = st_r.integrator_on[2];
    assign phase_b_integrator_on = st_r.integrator_on[1];
    assign phase_a_integrator_on = st_r.integrator_on[0];
    assign neutral_current_on    = st_r.neutral_on;
    assign phase_b_mode          = st_r.phase_b_mode;
    assign slot_skip             = st_r.slot_skip;
    assign mux_select            = st_r.mux_select;
    assign mux_valid             = st_r.mux_valid;
    assign gain_select           = st_r.gain_select;
    assign gain_factor           = st_r.gain_factor;
    assign gain_valid            = st_r.gain_valid;

endmodule

// >>> sim/msc_host.sv
`timescale 1ns/1ps
module msc_host
(
    input  wire logic               clk,
    input  wire msc_pkg::msc_word_t reg_rdata,
    output logic [7:0]              reg_addr,
    output logic                    reg_wr,
    output logic [15:0]             reg_wdata,
    output logic                    reg_rd
);
    import msc_pkg::*;

    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 26'h0;

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= (a == 8'h0a) ? (v & 16'h00ff) : (a == 8'h10) ? (v & 16'h0fff) : v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // Idle lines must not echo the last word
        {reg_addr, reg_wdata} <= {~a, ~v};
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        {reg_addr, reg_rd} <= {~a, 1'b0};
        @(posedge clk);
        v = reg_rdata;
    endtask
endmodule

// >>> sim/msc_top_properties.sv
`timescale 1ns/1ps
module msc_chk
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic        sag_evt,
    input wire logic        pulse1_reversed,
    input wire logic        pulse2_reversed,
    input wire logic        host_interrupt_n,
    input wire logic        neutral_integrator_on,
    input wire logic        phase_c_integrator_on,
    input wire logic        phase_b_integrator_on,
    input wire logic        phase_a_integrator_on,
    input wire logic        slot_skip,
    input wire logic [3:0]  mux_select,
    input wire logic        mux_valid,
    input wire msc_pkg::msc_phase_b_e phase_b_mode,
    input wire logic [2:0]  gain_select,
    input wire logic [5:0]  gain_factor,
    input wire logic        gain_valid
);
    import msc_pkg::*;
    logic [1:0]  up_r;
    logic [15:0] en_r;
    // Enable shadow; up_r hides the internal reset synchroniser window
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            {up_r, en_r} <= {2'h0, 16'h0001};
        else
            {up_r, en_r} <= {(up_r == 2'h3) ? up_r : up_r + 2'h1,
                             (reg_wr && reg_addr == 8'h06) ? reg_wdata : en_r};
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_cfg(logic [7:0] a);
        up_r == 2'h3 && reg_wr && reg_addr == a ##1 !reg_wr;
    endsequence
    property p_evt_irq;
        up_r == 2'h3 && sag_evt && en_r[10] && !reg_wr |-> ##2 !host_interrupt_n;
    endproperty
    a_evt_irq: assert property (p_evt_irq) else $error("irq not raised");
    property p_mask;
        up_r == 2'h3 && en_r == 16'h0000 |=> host_interrupt_n;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq raised");
    property p_flip2;
        up_r == 2'h3 && $changed(pulse2_reversed) && en_r[5] && !reg_wr |-> ##2 !host_interrupt_n;
    endproperty
    a_flip2: assert property (p_flip2) else $error("pulse2 flip missed");
    property p_flip1;
        up_r == 2'h3 && $changed(pulse1_reversed) && en_r[4] && !reg_wr |-> ##2 !host_interrupt_n;
    endproperty
    a_flip1: assert property (p_flip1) else $error("pulse1 flip missed");
    property p_integ;
        s_cfg(8'h0a) |=> {neutral_integrator_on, phase_c_integrator_on, phase_b_integrator_on,
                          phase_a_integrator_on} == $past(reg_wdata[7:4], 2);
    endproperty
    a_integ: assert property (p_integ) else $error("integrator enables wrong");
    property p_skip;
        s_cfg(8'h10) |=> slot_skip == $past(reg_wdata[7], 2);
    endproperty
    a_skip: assert property (p_skip) else $error("slot skip wrong");
    property p_mux;
        s_cfg(8'h10) |=> mux_select == $past(reg_wdata[11:8], 2)
                         && mux_valid == ($past(reg_wdata[11:8], 2) <= 4'h6);
    endproperty
    a_mux: assert property (p_mux) else $error("mux select wrong");
    property p_wiring;
        s_cfg(8'h0a) |=> phase_b_mode == ($past(reg_wdata[1], 2) ? MSC_PB_NEG_VA
                         : $past(reg_wdata[0], 2) ? MSC_PB_NEG_SUM : MSC_PB_OWN);
    endproperty
    a_wiring: assert property (p_wiring) else $error("phase b mode wrong");
    property p_gain;
        s_cfg(8'h10) |=> gain_select == $past(reg_wdata[6:4], 2)
                         && gain_valid == ($past(reg_wdata[6:4], 2) <= 3'h5)
                         && gain_factor == (($past(reg_wdata[6:4], 2) <= 3'h5)
                                            ? 6'h01 << $past(reg_wdata[6:4], 2) : 6'h01);
    endproperty
    a_gain: assert property (p_gain) else $error("gain decode wrong");
    property p_release;
        up_r == 2'h3 && reg_wr && reg_addr == 8'h04 && reg_wdata == 16'h0000
            && en_r == 16'h0400 && !sag_evt |-> ##2 host_interrupt_n;
    endproperty
    a_release: assert property (p_release) else $error("irq not released");
endmodule

bind msc_top msc_chk u_chk (.*);

// >>> sim/msc_top_tb.sv
`timescale 1ns/1ps
module msc_top_tb;
    import msc_pkg::*;
    logic         clk, arst_n, reg_wr, reg_rd, host_interrupt_n, slot_skip, mux_valid;
    logic         pulse1_reversed, pulse2_reversed, poweron_evt, watchdog_evt, gain_valid;
    logic         no_crossing_evt, sag_evt, high_line_volt_evt, excess_current_evt;
    logic         energy_wrap_evt, temp_ready_evt, supply_fail_evt, neutral_current_on;
    logic         neutral_integrator_on, phase_c_integrator_on;
    logic         phase_b_integrator_on, phase_a_integrator_on;
    logic [7:0]   reg_addr;
    logic [15:0]  reg_wdata, d;
    logic [6:0]   ev;
    logic [3:0]   mux_select;
    logic [2:0]   gain_select, g;
    logic [5:0]   gain_factor;
    msc_word_t    reg_rdata;
    msc_phase_b_e phase_b_mode, pb;
    int           n_mismatch, n_tests;
    int           pos [7] = '{11, 10, 9, 8, 3, 2, 1};
    logic [7:0]   adr [5] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h10};
    logic [15:0]  dflt [5] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0301};
    assign {no_crossing_evt, sag_evt, high_line_volt_evt, excess_current_evt,
            energy_wrap_evt, temp_ready_evt, supply_fail_evt} = ev;
    msc_top dut (.*);
    msc_host host (.*);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic fire(input logic [15:0] exp);
        tick(2);
        host.rd(8'h04, d);
        chk(d, exp);
        chk(16'(host_interrupt_n), 16'h0000);
        host.wr(8'h04, 16'h0000);
        tick(2);
        chk(16'(host_interrupt_n), 16'h0001);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out;
    end
    initial
    begin
        n_mismatch = 0;
        n_tests = 0;
        {arst_n, ev, pulse1_reversed, pulse2_reversed, poweron_evt, watchdog_evt} = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        tick(4);
        for (int i = 0; i < 5; i++)
        begin
            host.rd(adr[i], d);
            chk(d, dflt[i]);
        end
        host.rd(8'h0c, d);
        chk(d, 16'h0000);
        chk(16'(host_interrupt_n), 16'h0000);
        host.wr(8'h04, 16'h0000);
        host.wr(8'h06, 16'h0f3f);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk) ev <= 7'h40 >> i;
            @(posedge clk) ev <= 7'h00;
            fire(16'h0001 << pos[i]);
        end
        @(posedge clk) pulse1_reversed <= 1'b1;
        fire(16'h0010);
        @(posedge clk) pulse2_reversed <= 1'b1;
        fire(16'h0020);
        @(posedge clk) {poweron_evt, watchdog_evt} <= 2'h3;
        @(posedge clk) {poweron_evt, watchdog_evt} <= 2'h0;
        host.rd(8'h08, d);
        chk(d, 16'h00b4);
        host.wr(8'h08, 16'h0000);
        host.rd(8'h08, d);
        chk(d, 16'h0030);
        host.wr(8'h06, 16'h0000);
        @(posedge clk) ev <= 7'h20;
        @(posedge clk) ev <= 7'h00;
        tick(3);
        chk(16'(host_interrupt_n), 16'h0001);
        host.wr(8'h06, 16'h0400);
        tick(2);
        chk(16'(host_interrupt_n), 16'h0000);
        host.wr(8'h04, 16'h0000);
        tick(2);
        chk(16'(host_interrupt_n), 16'h0001);
        // Event and host clear in one cycle: the event must survive
        fork
            host.wr(8'h04, 16'h0000);
            begin
                @(posedge clk) ev <= 7'h20;
                @(posedge clk) ev <= 7'h00;
            end
        join
        fire(16'h0400);
        for (int k = 0; k < 16; k++)
        begin
            d = {8'h00, 4'(k), 1'b0, 3'(k)};
            pb = d[1] ? MSC_PB_NEG_VA : d[0] ? MSC_PB_NEG_SUM : MSC_PB_OWN;
            host.wr(8'h0a, d);
            tick(2);
            chk(16'({neutral_integrator_on, phase_c_integrator_on, phase_b_integrator_on,
                phase_a_integrator_on, neutral_current_on}), 16'({d[7:4], d[2]}));
            chk(16'(phase_b_mode), 16'(pb));
            g = 3'(k);
            d = {4'h0, 4'(k), k[0], g, 4'h0};
            host.wr(8'h10, d);
            tick(2);
            chk(16'({slot_skip, mux_select, mux_valid}), 16'({d[7], d[11:8], d[11:8] <= 4'h6}));
            chk(16'({gain_select, gain_factor, gain_valid}),
                16'({g, ((g <= 3'h5) ? 6'h01 << g : 6'h01), g <= 3'h5}));
        end
        close_out;
    end
endmodule
